//--- src/twm_pkg.sv
// constants shared by the two-wire master controller files
package twm_pkg;
    // slave type codes in address bits 7-4
    localparam logic [3:0] MEM_TYPE_CODE = 4'ha;
    localparam logic [3:0] REG_TYPE_CODE = 4'hd;
    // highest legal register address
    localparam logic [7:0] REG_ADDR_MAX = 8'h18;
    // direction bit values in address bit 0
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    // bus timing: quarter bit period in ns, cycles at 40 MHz (25 ns)
    localparam int QUARTER_NS = 1250;
    localparam int CLK_NS = 25;
    localparam int QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] QUARTER_CNT = 8'(QUARTER_CYC);
    // bit count per byte
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // command codes
    localparam logic [2:0] CMD_MEM_WRITE = 3'h0;
    localparam logic [2:0] CMD_MEM_READ = 3'h1;
    localparam logic [2:0] CMD_MEM_SEL_READ = 3'h2;
    localparam logic [2:0] CMD_REG_WRITE = 3'h3;
    localparam logic [2:0] CMD_REG_READ = 3'h4;
    localparam logic [2:0] CMD_REG_SEL_READ = 3'h5;
    // bus phases of the master sequencer
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_START = 4'h1,
        ST_SLAVE = 4'h2,
        ST_ADDR_HI = 4'h3,
        ST_ADDR_LO = 4'h4,
        ST_WDATA = 4'h5,
        ST_RSTART = 4'h6,
        ST_RSLAVE = 4'h7,
        ST_RDATA = 4'h8,
        ST_STOP = 4'h9
    } phase_t;
endpackage

//--- src/twm_bit_engine.sv
// bit-level engine: start, stop and one byte plus acknowledge slot
`timescale 1ns/100ps
module twm_bit_engine
    import twm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic op_start,
    input wire logic op_stop,
    input wire logic op_byte,
    input wire logic [7:0] tx_byte,
    input wire logic tx_ack_release,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_oe,
    output logic sda_oe,
    output logic busy,
    output logic done,
    output logic [7:0] rx_byte_r,
    output logic ack_seen_r
);
    // engine phases
    typedef enum logic [2:0] {
        E_IDLE = 3'h0,
        E_START = 3'h1,
        E_BIT = 3'h2,
        E_ACK = 3'h3,
        E_STOP = 3'h4
    } eng_t;

    eng_t st_r, st_nxt;
    logic [1:0] q_r; // quarter index inside a bit
    logic [7:0] tick_r; // quarter timer
    logic [3:0] bit_r; // bits sent in current byte
    logic [7:0] sh_r; // transmit shift register
    logic scl_oe_r, sda_oe_r;
    logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r; // pin synchronisers
    logic release_r; // our side lets the line go in the ack slot
    wire tick = (tick_r == QUARTER_CNT - 8'h01);
    wire last_q = tick && (q_r == 2'h3);

    assign scl_oe = scl_oe_r;
    assign sda_oe = sda_oe_r;
    assign busy = (st_r != E_IDLE);
    assign done = busy && last_q && (st_nxt == E_IDLE);

    // pins cross from outside; two flops before use
    always_ff @(posedge sys_clk) begin
        scl_s1_r <= scl_in;
        scl_s2_r <= scl_s1_r;
        sda_s1_r <= sda_in;
        sda_s2_r <= sda_s1_r;
    end

    // phase sequencing per completed bit
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            E_IDLE: begin
                if (op_start) st_nxt = E_START;
                else if (op_stop) st_nxt = E_STOP;
                else if (op_byte) st_nxt = E_BIT;
            end
            E_START: if (last_q) st_nxt = E_IDLE;
            E_BIT: if (last_q && bit_r == BYTE_BITS - 4'h1) st_nxt = E_ACK;
            E_ACK: if (last_q) st_nxt = E_IDLE;
            E_STOP: if (last_q) st_nxt = E_IDLE;
            default: st_nxt = E_IDLE;
        endcase
    end

    // timer, bit counter and shift register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            st_r <= E_IDLE;
            q_r <= 2'h0;
            tick_r <= 8'h00;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            rx_byte_r <= 8'h00;
            ack_seen_r <= 1'b0;
            release_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (st_r == E_IDLE) begin
                q_r <= 2'h0;
                tick_r <= 8'h00;
                bit_r <= 4'h0;
                if (op_byte) begin
                    sh_r <= tx_byte;
                    release_r <= tx_ack_release;
                end
            end else begin
                tick_r <= tick ? 8'h00 : tick_r + 8'h01;
                if (tick) q_r <= q_r + 2'h1;
                // sample while clock high, msb first [R21] [R13]
                if (tick && q_r == 2'h2 && st_r == E_BIT)
                    rx_byte_r <= {rx_byte_r[6:0], sda_s2_r};
                // low in ninth slot means acknowledge [R1]
                if (tick && q_r == 2'h2 && st_r == E_ACK)
                    ack_seen_r <= ~sda_s2_r;
                if (last_q && st_r == E_BIT) begin
                    bit_r <= bit_r + 4'h1;
                    sh_r <= {sh_r[6:0], 1'b0};
                end
            end
        end
    end

    // line drive: data changes only while clock low, except at start and stop [R21]
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            case (st_r)
                E_START: begin
                    // high clock then data falls, then clock low
                    scl_oe_r <= (q_r == 2'h3);
                    sda_oe_r <= (q_r >= 2'h2);
                end
                E_BIT: begin
                    scl_oe_r <= (q_r == 2'h0) || (q_r == 2'h3);
                    sda_oe_r <= ~sh_r[7];
                end
                E_ACK: begin
                    scl_oe_r <= (q_r == 2'h0) || (q_r == 2'h3);
                    // release when slave answers or on the last read byte, else drive ack [R1]
                    sda_oe_r <= ~release_r;
                end
                E_STOP: begin
                    // data low, clock rises, then data rises
                    scl_oe_r <= (q_r == 2'h0);
                    sda_oe_r <= (q_r <= 2'h1);
                end
                E_IDLE: begin
                    // hold both lines between steps: letting go here would
                    // raise the clock with data low and make a false stop [R21]
                    scl_oe_r <= scl_oe_r;
                    sda_oe_r <= sda_oe_r;
                end
                default: begin
                    scl_oe_r <= 1'b0;
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end
endmodule // twm_bit_engine

//--- src/twm_master.sv
// two-wire bus master driving the memory and register logical devices
`timescale 1ns/100ps
// Notes on behaviour
// R1: ninth clock acknowledges; transmitter releases data
// R2: missing acknowledge aborts; device addressable again
// R3: memory device type code in bits 7-4
// R4: register device code; leaves memory untouched
// R5: bits 2-1 match device select straps
// R6: address bit zero: one read, zero write
// R7: two memory address bytes, upper first
// R8: unused high address bits sent as zero
// R9: device increments memory address, wraps zero
// R10: separate memory and register address latches
// R11: reads from current address, unlimited length
// R12: register address above 18h gets nack
// R13: bytes eight bits, msb first, acknowledged
// R14: memory byte commits at eighth bit
// R15: master ends read with nack then stop
// R16: selective read: write address, repeated start
// R17: device drives read data next clock
// R18: register reads auto-increment like memory
// R19: every write supplies an address first
// R20: register address top three bits zero
// R21: data sampled high, stable while clock high
// R22: master never acknowledges the last byte
// R23: start aborts anything in progress
// R24: stop aborts pending operation
// R25: supply trip aborts; new start needed
// R26: register address wraps past highest
module twm_master
    import twm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [2:0] cmd_op,
    input wire logic [1:0] cmd_sel,
    input wire logic [15:0] cmd_addr,
    input wire logic [15:0] cmd_len,
    output logic wr_ready,
    input wire logic [7:0] wr_data,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic done,
    output logic nack_err,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe
);
    // how the pieces fit together:
    // - this module owns the transaction order: start, slave byte,
    //   address bytes, data bytes or repeated start, then stop
    // - the bit engine below owns the line timing inside one step
    // - one engine step is requested per phase; issued_r blocks a
    //   second request until the engine reports the step done
    // - a missing acknowledge anywhere except in read data sends the
    //   sequencer straight to stop and raises nack_err
    // - read data is acknowledged byte by byte except the final one,
    //   which is left unacknowledged so the device lets the bus go
    //
    // limitations a user must know:
    // - no clock stretching: a slave holding the clock low is not
    //   waited for, so only devices that never stretch may be used
    // - register addresses are cut to five bits before sending; the
    //   top three bits of the register address byte always go as zero
    // - a length of zero is taken as one byte, since every read must
    //   end on an unacknowledged byte and every write needs data
    // - the memory address is always sent as two bytes; the device
    //   drops whatever bits its density does not use
    //
    // trade-off: the bus runs at the slow legacy rate so that every device on
    // the bus copes, at the cost of a longer count in the quarter-bit timer

    // sequencer state
    phase_t ph_r, ph_nxt;
    logic [2:0] op_r; // latched command
    logic [1:0] sel_r; // device select straps to address
    logic [15:0] addr_r; // start address
    logic [15:0] left_r; // bytes remaining
    logic issued_r; // engine request already given in this phase
    logic done_r, nack_r, rd_valid_r;
    logic [7:0] rd_data_r;
    logic e_start, e_stop, e_byte, e_busy, e_done, e_ack, e_rel;
    logic [7:0] e_tx, e_rx;

    // open-drain: outputs only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign done = done_r;
    assign nack_err = nack_r;
    assign rd_valid = rd_valid_r;
    assign rd_data = rd_data_r;
    assign cmd_ready = (ph_r == ST_IDLE);

    // build a slave address byte [R3] [R4] [R5] [R6]
    function automatic logic [7:0] slave_byte(input logic [2:0] op, input logic [1:0] sel, input logic dir);
        logic [3:0] code;
        code = (op >= CMD_REG_WRITE) ? REG_TYPE_CODE : MEM_TYPE_CODE;
        return {code, 1'b0, sel, dir};
    endfunction

    wire is_reg = (op_r >= CMD_REG_WRITE);
    wire is_cur_read = (op_r == CMD_MEM_READ) || (op_r == CMD_REG_READ);
    wire is_write = (op_r == CMD_MEM_WRITE) || (op_r == CMD_REG_WRITE);
    wire last_byte = (left_r == 16'h0001);
    wire rdata = (ph_r == ST_RDATA);
    wire need_byte = (ph_r == ST_WDATA);

    // byte to place on the bus in each phase
    assign e_tx = (ph_r == ST_SLAVE) ? slave_byte(op_r, sel_r, is_cur_read ? DIR_READ : DIR_WRITE) :
                  (ph_r == ST_RSLAVE) ? slave_byte(op_r, sel_r, DIR_READ) :
                  (ph_r == ST_ADDR_HI) ? addr_r[15:8] : // upper byte first [R7] [R8]
                  (ph_r == ST_ADDR_LO) ? addr_r[7:0] :
                  (ph_r == ST_WDATA) ? wr_data : 8'hff; // ones release the line for read data [R17]
    // on read data: ack all but the last byte [R22] [R15]
    assign e_rel = rdata ? last_byte : 1'b1;
    assign e_start = !issued_r && ((ph_r == ST_START) || (ph_r == ST_RSTART));
    assign e_stop = !issued_r && (ph_r == ST_STOP);
    assign e_byte = !issued_r && !e_start && !e_stop && (ph_r != ST_IDLE);
    assign wr_ready = need_byte && e_byte && !e_busy;

    twm_bit_engine u_eng (
        .sys_clk(sys_clk),
        .srst(srst),
        .op_start(e_start),
        .op_stop(e_stop),
        .op_byte(e_byte),
        .tx_byte(e_tx),
        .tx_ack_release(e_rel),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_oe(scl_oe),
        .sda_oe(sda_oe),
        .busy(e_busy),
        .done(e_done),
        .rx_byte_r(e_rx),
        .ack_seen_r(e_ack)
    );

    // ack as sampled at the end of the slot's third quarter, clock high, a quarter before done
    wire acked = e_ack;

    // phase sequencing on each finished engine step
    always_comb begin
        ph_nxt = ph_r;
        case (ph_r)
            ST_IDLE: if (cmd_valid) ph_nxt = ST_START;
            // every write and selective read sends an address [R19] [R16]
            ST_START: if (e_done) ph_nxt = ST_SLAVE;
            ST_SLAVE: if (e_done) begin
                if (!acked) ph_nxt = ST_STOP; // not answered: give up [R2]
                else if (is_cur_read) ph_nxt = ST_RDATA; // current address read [R11] [R18]
                else if (is_reg) ph_nxt = ST_ADDR_LO; // single register address byte
                else ph_nxt = ST_ADDR_HI;
            end
            ST_ADDR_HI: if (e_done) ph_nxt = acked ? ST_ADDR_LO : ST_STOP;
            ST_ADDR_LO: if (e_done) begin
                // illegal register address shows as nack [R12]
                if (!acked) ph_nxt = ST_STOP;
                else if (is_write) ph_nxt = ST_WDATA;
                else ph_nxt = ST_RSTART; // repeated start abandons the write [R16]
            end
            ST_WDATA: if (e_done) ph_nxt = (!acked || last_byte) ? ST_STOP : ST_WDATA; // [R14]
            ST_RSTART: if (e_done) ph_nxt = ST_RSLAVE;
            ST_RSLAVE: if (e_done) ph_nxt = acked ? ST_RDATA : ST_STOP;
            ST_RDATA: if (e_done) ph_nxt = last_byte ? ST_STOP : ST_RDATA; // nack then stop [R15]
            ST_STOP: if (e_done) ph_nxt = ST_IDLE;
            default: ph_nxt = ST_IDLE;
        endcase
    end

    // command latch and engine handshake
    // the byte counter only moves on data bytes, never on address
    // bytes, so the count the user asked for is what travels, a zero count going as one byte, unless a nack ends it first
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ph_r <= ST_IDLE;
            op_r <= CMD_MEM_WRITE;
            sel_r <= 2'h0;
            addr_r <= 16'h0000;
            left_r <= 16'h0000;
            issued_r <= 1'b0;
        end else begin
            ph_r <= ph_nxt;
            if (ph_r == ST_IDLE && cmd_valid) begin
                op_r <= cmd_op;
                sel_r <= cmd_sel;
                // register address upper bits kept zero [R20]
                addr_r <= (cmd_op >= CMD_REG_WRITE) ? {8'h00, 3'h0, cmd_addr[4:0]} : cmd_addr;
                left_r <= (cmd_len == 16'h0000) ? 16'h0001 : cmd_len;
            end
            if (e_done) issued_r <= 1'b0;
            else if (e_start || e_stop || e_byte) issued_r <= 1'b1;
            if (e_done && (rdata || need_byte) && left_r != 16'h0000)
                left_r <= left_r - 16'h0001;
        end
    end

    // results: read byte and completion pulses, error level
    // nack_err is a level so the user may look at it after done;
    // it clears only when the next command is taken
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rd_valid_r <= 1'b0;
            rd_data_r <= 8'h00;
            done_r <= 1'b0;
            nack_r <= 1'b0;
        end else begin
            rd_valid_r <= e_done && rdata;
            if (e_done && rdata) rd_data_r <= e_rx;
            done_r <= e_done && (ph_r == ST_STOP);
            if (ph_r == ST_IDLE && cmd_valid) nack_r <= 1'b0;
            else if (e_done && !acked && !rdata && ph_r != ST_START && ph_r != ST_RSTART && ph_r != ST_STOP)
                nack_r <= 1'b1;
        end
    end
endmodule // twm_master

//--- dv/twm_master_assertions.sv
// checker of master handshakes and bus line timing
`timescale 1ns/100ps
module twm_master_assertions
    import twm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic wr_ready,
    input wire logic rd_valid,
    input wire logic done,
    input wire logic nack_err,
    input wire logic scl_oe,
    input wire logic sda_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // idle means both lines released
    a_idle_lines_free: assert property (cmd_ready |-> !scl_oe && !sda_oe)
        else $error("line held while idle");
    a_accept_goes_busy: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
        else $error("ready after accept");
    a_done_single: assert property (done |=> !done)
        else $error("done longer than one cycle");
    a_rd_single: assert property (rd_valid |=> !rd_valid)
        else $error("read strobe too long");
    a_xfer_while_busy: assert property (rd_valid || wr_ready |-> !cmd_ready)
        else $error("data strobe while idle");
    // data falling with clock released is a start: clock must follow
    a_start_clock_low: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:120] scl_oe)
        else $error("start not followed by clock");
    // data rising with clock released is a stop
    a_stop_then_done: assert property ($fell(sda_oe) && !scl_oe && !$past(scl_oe) |-> ##[0:300] done)
        else $error("stop without done");
    a_clock_low_span: assert property ($rose(scl_oe) |=> scl_oe [*8])
        else $error("clock low too short");
    a_nack_stops: assert property ($rose(nack_err) |-> ##[1:600] done)
        else $error("missing ack did not end transfer");
    a_err_held: assert property ($fell(nack_err) |-> $past(cmd_valid && cmd_ready))
        else $error("error flag cleared early");
    c_read: cover property (rd_valid);
    c_write: cover property (wr_ready);
    c_nack: cover property ($rose(nack_err));
endmodule // twm_master_assertions

bind twm_master twm_master_assertions chk (.sys_clk(sys_clk), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .wr_ready(wr_ready), .rd_valid(rd_valid), .done(done),
    .nack_err(nack_err), .scl_oe(scl_oe), .sda_oe(sda_oe));

//--- dv/twm_dev_model.sv
// behavioural two-wire device with memory and register spaces
`timescale 1ns/100ps
module twm_dev_model
    import twm_pkg::*;
(
    input wire logic scl,
    input wire logic sda,
    input wire logic [1:0] strap,
    output logic sda_oe
);
    logic [7:0] mem [256]; // small density: upper address bits ignored
    logic [7:0] regs [25];
    logic [7:0] sh, ob; // byte in, byte out
    logic [15:0] maddr;
    logic [4:0] raddr; // latches kept apart
    int st, bn; // 0 idle 1 slave 2 hi 3 lo 4 write 5 read
    logic isreg, mack, wasrd;
    initial begin
        sda_oe = 0;
        st = 0;
        bn = 0;
        maddr = 0;
        raddr = 0;
        foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
        foreach (regs[i]) regs[i] = 8'(i) ^ 8'ha5;
    end
    // advance one latch, register space wraps past its top
    task automatic bump();
        if (isreg) raddr = (raddr == 5'(REG_ADDR_MAX)) ? 5'h00 : raddr + 5'h01;
        else maddr = maddr + 16'h0001;
    endtask
    // the supply never dips in these runs; a dip would abort like a start
    // start aborts and expects an address
    always @(negedge sda) if (scl) begin st = 1; bn = -1; sda_oe = 0; end
    // stop aborts pending work
    always @(posedge sda) if (scl) begin st = 0; sda_oe = 0; end
    // sample while clock high, msb first
    always @(posedge scl) if (st != 0) begin if (bn < 8) sh = {sh[6:0], sda}; else mack = !sda; end
    // drive on falling clock
    always @(negedge scl) if (st != 0) begin
        bn = bn + 1;
        if (bn == 8) begin
            wasrd = (st == 5);
            sda_oe = 0; // release for the ack slot
            if (st == 1) begin
                if ((sh[7:4] == MEM_TYPE_CODE || sh[7:4] == REG_TYPE_CODE) && sh[2:1] == strap) begin
                    isreg = (sh[7:4] == REG_TYPE_CODE); // register path never touches memory
                    st = sh[0] ? 5 : (isreg ? 3 : 2);
                    sda_oe = 1;
                end else st = 0; // not ours: silent
            end else if (st == 2) begin maddr[15:8] = sh; st = 3; sda_oe = 1; end
            else if (st == 3 && isreg) begin
                if (sh <= REG_ADDR_MAX) begin raddr = 5'(sh); st = 4; sda_oe = 1; end
                else st = 0;
            end else if (st == 3) begin maddr[7:0] = sh; st = 4; sda_oe = 1; end
            else if (st == 4) begin
                if (isreg) regs[raddr] = sh;
                else mem[maddr[7:0]] = sh; // committed before ack
                bump();
                sda_oe = 1;
            end
        end else if (bn == 9) begin
            bn = 0;
            sda_oe = 0;
            if (st == 5) begin
                if (wasrd && !mack) st = 0; // master nack ends read
                else begin
                    ob = isreg ? regs[raddr] : mem[maddr[7:0]]; // current address
                    bump();
                    sda_oe = !ob[7];
                end
            end
        end else if (st == 5 && bn > 0) sda_oe = !ob[7 - bn];
    end
endmodule // twm_dev_model

//--- dv/twm_master_bench.sv
// self-checking bench for the two-wire master against a device model
`timescale 1ns/100ps
module twm_master_bench
    import twm_pkg::*;
;
    localparam logic [1:0] STRAP = 2'h2; // strapped device select
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_op = 3'h0;
    logic [1:0] cmd_sel = 2'h0;
    logic [15:0] cmd_addr = 16'h0000;
    logic [15:0] cmd_len = 16'h0001;
    logic [7:0] wbuf [4] = '{default: 8'h00};
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic cmd_ready, wr_ready, rd_valid, done, nack_err, scl_oe, sda_oe, mdl_oe;
    logic [7:0] rq [$]; // bytes read back
    int wi = 0;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    // open-drain lines with pull-ups
    wire logic scl = !scl_oe;
    wire logic sda = !(sda_oe || mdl_oe);
    assign wr_data = wbuf[wi];
    twm_master dut (.sys_clk, .srst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_sel, .cmd_addr, .cmd_len,
        .wr_ready, .wr_data, .rd_valid, .rd_data, .done, .nack_err, .scl_in(scl), .sda_in(sda),
        .scl_out(), .scl_oe, .sda_out(), .sda_oe);
    twm_dev_model dev (.scl(scl), .sda(sda), .strap(STRAP), .sda_oe(mdl_oe));
    always #12.5 sys_clk = !sys_clk;
    // collect read bytes, step write data
    always @(posedge sys_clk) begin
        if (rd_valid) rq.push_back(rd_data);
        if (wr_ready) wi <= wi + 1;
    end
    // hang guard: well above the ~70k cycles the tests need
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_flag(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask
    // one command, held until accepted, then wait for done
    task automatic run(input logic [2:0] op, input logic [15:0] addr, input logic [15:0] len,
        input logic [1:0] sel = STRAP);
        rq.delete();
        wi = 0;
        cmd_op <= op;
        cmd_sel <= sel;
        cmd_addr <= addr;
        cmd_len <= len;
        cmd_valid <= 1'b1;
        @(negedge sys_clk);
        while (cmd_ready !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        while (done !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
    endtask
    // write across the top of memory, read back selectively
    task automatic t_mem();
        wbuf = '{8'h11, 8'h22, 8'h33, 8'h00};
        run(CMD_MEM_WRITE, 16'h00fe, 16'h0003);
        check_flag(nack_err, 1'b0);
        run(CMD_MEM_SEL_READ, 16'h00fe, 16'h0003);
        check_byte(8'(rq.size()), 8'h03);
        for (int i = 0; i < 3; i++) check_byte(rq[i], wbuf[i]);
        $display("test mem done");
    endtask
    // register write at the top, read wraps, memory latch kept
    task automatic t_reg();
        wbuf = '{8'h44, 8'h55, 8'h00, 8'h00};
        run(CMD_REG_WRITE, 16'h0017, 16'h0002);
        run(CMD_REG_SEL_READ, 16'h0017, 16'h0003);
        check_byte(rq[0], 8'h44);
        check_byte(rq[1], 8'h55);
        check_byte(rq[2], 8'ha5);
        run(CMD_MEM_READ, 16'h0000, 16'h0001);
        check_byte(rq[0], 8'h01 ^ 8'h5a);
        $display("test reg done");
    endtask
    // every select value, only the strapped one answers
    task automatic t_sel();
        for (int s = 0; s < 4; s++) begin
            run(CMD_REG_READ, 16'h0000, 16'h0001, 2'(s));
            check_flag(nack_err, 2'(s) != STRAP);
            if (2'(s) == STRAP) check_byte(rq[0], 8'h01 ^ 8'ha5);
        end
        $display("test sel done");
    endtask
    // register address just past and at the limit
    task automatic t_bad();
        run(CMD_REG_WRITE, 16'h0019, 16'h0001);
        check_flag(nack_err, 1'b1);
        run(CMD_REG_WRITE, 16'h0018, 16'h0001);
        check_flag(nack_err, 1'b0);
        $display("test bad done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // reset, then the tests in order
    initial begin
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        t_mem();
        t_reg();
        t_sel();
        t_bad();
        finish_test();
    end
endmodule // twm_master_bench
